/* rtl/oss_device.sv */
// Device end: status byte, output selection and communication-loss safe state.

module oss_device #(
  parameter int COMM_TIMEOUT_CYC = oss_pkg::COMM_TIMEOUT_CYC, // Idle cycles that mean communication loss.
  parameter int ZC_TIMEOUT_CYC = oss_pkg::ZC_TIMEOUT_CYC // Cycles without a mains edge before dropout.
) (
  input wire logic clk, // 100 MHz clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  oss_link_if.dev lnk, // Link to the master.
  input wire logic zc_polarity, // Mains zero-cross input, high in positive half-wave.
  input wire logic [3:0] fire_sense_stb, // Pulse just before a channel's triac fires.
  input wire logic [3:0] neutral_ok, // Neutral return path seen through the load.
  output logic [3:0] chan_is_analog, // Channel configured as analog.
  output logic [3:0] chan_digital_cmd, // Digital command per channel.
  output logic [31:0] chan_analog_cmd, // Analog command per channel, ch1 in bits 7:0.
  output logic safe_state_active // High while the safe state is in force.
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] mode_r;
  logic [3:0] safe_dig_r;
  logic [7:0] safe_ana_r [oss_pkg::NCH];
  logic [3:0] out_type_r;

  // Configuration writes arrive over the link; unknown indices are ignored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= oss_pkg::RST_SAFE_STATE_MODE;
      safe_dig_r <= oss_pkg::RST_SAFE_DIGITAL[3:0];
      out_type_r <= oss_pkg::RST_OUTPUT_TYPE[3:0];
      for (int i = 0; i < oss_pkg::NCH; i++) begin
        safe_ana_r[i] <= oss_pkg::RST_SAFE_ANALOG;
      end
    end else if (lnk.cfg_wr) begin
      case (lnk.cfg_idx)
        oss_pkg::CFG_SAFE_STATE_MODE: mode_r <= lnk.cfg_data;
        oss_pkg::CFG_SAFE_DIGITAL_VALUE: safe_dig_r <= lnk.cfg_data[3:0];
        oss_pkg::CFG_OUTPUT_TYPE: out_type_r <= lnk.cfg_data[3:0];
        default: begin
          if (lnk.cfg_idx >= oss_pkg::CFG_SAFE_ANALOG_CH1 && lnk.cfg_idx <= oss_pkg::CFG_SAFE_ANALOG_CH4) begin
            safe_ana_r[2'(lnk.cfg_idx - oss_pkg::CFG_SAFE_ANALOG_CH1)] <= oss_pkg::ana_clamp(lnk.cfg_data);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Cyclic transfer capture and communication watchdog
  // ----------------------------------------------------------------
  logic [31:0] comm_cnt_r;
  logic comm_lost;
  logic valid_in;
  logic [3:0] req_dig_r;
  logic [7:0] req_ana_r [oss_pkg::NCH];
  logic [3:0] hold_dig_r;
  logic [7:0] hold_ana_r [oss_pkg::NCH];

  // Only bit 0 carries meaning; reserved bits are masked off.
  assign valid_in = |(lnk.cyc_valid & oss_pkg::VALID_MASK);
  assign comm_lost = comm_cnt_r >= 32'(COMM_TIMEOUT_CYC);

  // A transfer restarts the watchdog; the count saturates so loss stays flagged.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comm_cnt_r <= 32'h0;
    end else if (lnk.cyc_stb) begin
      comm_cnt_r <= 32'h0;
    end else if (!comm_lost) begin
      comm_cnt_r <= comm_cnt_r + 32'h1;
    end
  end

  // Task requests are stored on every transfer and copied for hold mode when valid.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_dig_r <= 4'h0;
      hold_dig_r <= 4'h0;
      for (int i = 0; i < oss_pkg::NCH; i++) begin
        req_ana_r[i] <= 8'h00;
        hold_ana_r[i] <= 8'h00;
      end
    end else if (lnk.cyc_stb) begin
      req_dig_r <= lnk.cyc_digital;
      if (valid_in) begin
        hold_dig_r <= lnk.cyc_digital;
      end
      for (int i = 0; i < oss_pkg::NCH; i++) begin
        req_ana_r[i] <= oss_pkg::ana_clamp(lnk.cyc_analog[8*i +: 8]);
        if (valid_in) begin
          hold_ana_r[i] <= oss_pkg::ana_clamp(lnk.cyc_analog[8*i +: 8]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Safe-state machine
  // ----------------------------------------------------------------
  oss_pkg::oss_dev_e state_r;
  oss_pkg::oss_dev_e state_nxt;

  // D_INIT also records that the valid bit has never been set.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      oss_pkg::D_INIT: begin
        if (lnk.cyc_stb && valid_in) begin
          state_nxt = oss_pkg::D_NORMAL;
        end
      end
      oss_pkg::D_NORMAL: begin
        if (comm_lost || (lnk.cyc_stb && !valid_in)) begin
          state_nxt = oss_pkg::D_SAFE;
        end
      end
      oss_pkg::D_SAFE: begin
        if (lnk.cyc_stb && valid_in) begin
          state_nxt = oss_pkg::D_NORMAL;
        end
      end
      default: state_nxt = oss_pkg::D_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= oss_pkg::D_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  logic [3:0] dig_nxt;
  logic [31:0] ana_nxt;

  // The next state is used so outputs change in the cycle after the transfer.
  always_comb begin
    dig_nxt = 4'h0;
    ana_nxt = 32'h0;
    for (int i = 0; i < oss_pkg::NCH; i++) begin
      case (state_nxt)
        oss_pkg::D_NORMAL: begin
          dig_nxt[i] = req_dig_r[i];
          ana_nxt[8*i +: 8] = req_ana_r[i];
          if (lnk.cyc_stb) begin
            dig_nxt[i] = lnk.cyc_digital[i];
            ana_nxt[8*i +: 8] = oss_pkg::ana_clamp(lnk.cyc_analog[8*i +: 8]);
          end
        end
        oss_pkg::D_SAFE: begin
          if (mode_r == oss_pkg::MODE_HOLD) begin
            dig_nxt[i] = hold_dig_r[i];
            ana_nxt[8*i +: 8] = hold_ana_r[i];
          end else begin
            dig_nxt[i] = safe_dig_r[i];
            ana_nxt[8*i +: 8] = safe_ana_r[i];
          end
        end
        default: begin
          dig_nxt[i] = 1'b0;
          ana_nxt[8*i +: 8] = 8'h00;
        end
      endcase
      // Each channel drives only the command that matches its type.
      if (out_type_r[i]) begin
        dig_nxt[i] = 1'b0;
      end else begin
        ana_nxt[8*i +: 8] = 8'h00;
      end
    end
  end

  // Outputs settle one clock after a transfer, far inside any bus cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_digital_cmd <= 4'h0;
      chan_analog_cmd <= 32'h0;
      chan_is_analog <= oss_pkg::RST_OUTPUT_TYPE[3:0];
      safe_state_active <= 1'b0;
      lnk.module_healthy <= 1'b0;
    end else begin
      chan_digital_cmd <= dig_nxt;
      chan_analog_cmd <= ana_nxt;
      chan_is_analog <= out_type_r;
      safe_state_active <= state_nxt == oss_pkg::D_SAFE;
      lnk.module_healthy <= state_nxt == oss_pkg::D_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  logic [3:0] no_load_current;
  logic mains_polarity_flag;
  logic mains_sync_lost_flag;
  logic zc_prev_r;
  logic [31:0] zc_cnt_r;
  logic [3:0] chan_on;

  // A channel is activated when its current command is non-zero.
  always_comb begin
    for (int i = 0; i < oss_pkg::NCH; i++) begin
      chan_on[i] = chan_digital_cmd[i] | (|chan_analog_cmd[8*i +: 8]);
    end
  end

  // A firing sample wins over the clear of an idle channel.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      no_load_current <= 4'h0;
    end else begin
      for (int i = 0; i < oss_pkg::NCH; i++) begin
        if (fire_sense_stb[i]) begin
          no_load_current[i] <= ~neutral_ok[i];
        end else if (!chan_on[i]) begin
          no_load_current[i] <= 1'b0;
        end
      end
    end
  end

  // Any mains edge restarts the dropout timer; a stuck input is reported lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zc_prev_r <= 1'b0;
      zc_cnt_r <= 32'h0;
      mains_polarity_flag <= 1'b0;
      mains_sync_lost_flag <= 1'b0;
    end else begin
      zc_prev_r <= zc_polarity;
      mains_polarity_flag <= zc_polarity;
      if (zc_polarity != zc_prev_r) begin
        zc_cnt_r <= 32'h0;
        mains_sync_lost_flag <= 1'b0;
      end else if (zc_cnt_r >= 32'(ZC_TIMEOUT_CYC)) begin
        mains_sync_lost_flag <= 1'b1;
      end else begin
        zc_cnt_r <= zc_cnt_r + 32'h1;
      end
    end
  end

  // Packed byte; the separate flags sit at the same bit positions.
  assign lnk.output_status = {mains_sync_lost_flag, 2'b00, mains_polarity_flag, no_load_current};

endmodule : oss_device

/* shared/oss_pkg.sv */
// Shared constants, types and helpers for the output status and safe-state link.
package oss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MIN_CYCLE_US = 250;
  localparam int MIN_CYCLE_CYC = MIN_CYCLE_US * CLK_MHZ;
  localparam int MIN_UPDATE_US = 150;
  localparam int MIN_UPDATE_CYC = MIN_UPDATE_US * CLK_MHZ;
  localparam int COMM_TIMEOUT_US = 1000;
  localparam int COMM_TIMEOUT_CYC = COMM_TIMEOUT_US * CLK_MHZ;
  localparam int ZC_TIMEOUT_US = 15000;
  localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Device configuration indices and reset values
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam logic [2:0] CFG_SAFE_STATE_MODE = 3'h0;
  localparam logic [2:0] CFG_SAFE_DIGITAL_VALUE = 3'h1;
  localparam logic [2:0] CFG_SAFE_ANALOG_CH1 = 3'h2;
  localparam logic [2:0] CFG_SAFE_ANALOG_CH4 = 3'h5;
  localparam logic [2:0] CFG_OUTPUT_TYPE = 3'h6;
  localparam logic [7:0] RST_SAFE_STATE_MODE = 8'h00;
  localparam logic [7:0] RST_SAFE_DIGITAL = 8'h00;
  localparam logic [7:0] RST_SAFE_ANALOG = 8'h00;
  localparam logic [7:0] RST_OUTPUT_TYPE = 8'h0F;
  localparam logic [7:0] MODE_STATIC = 8'h00;
  localparam logic [7:0] MODE_HOLD = 8'h01;
  localparam logic [7:0] ANALOG_MAX = 8'h64;
  localparam logic [7:0] VALID_MASK = 8'h01;
  localparam int ST_POLARITY_BIT = 4;
  localparam int ST_SYNC_LOST_BIT = 7;

  // ----------------------------------------------------------------
  // Master register map
  // ----------------------------------------------------------------
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_DIGITAL = 6'h04;
  localparam logic [5:0] A_ANALOG_CH1 = 6'h08;
  localparam logic [5:0] A_ANALOG_CH4 = 6'h14;
  localparam logic [5:0] A_STATUS = 6'h18;
  localparam logic [5:0] A_HEALTH = 6'h1C;
  localparam logic [5:0] A_CONFIG = 6'h20;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    D_INIT = 2'b00,
    D_NORMAL = 2'b01,
    D_SAFE = 2'b10
  } oss_dev_e;

  typedef enum logic [1:0] {
    M_WAIT = 2'b00,
    M_SEND = 2'b01
  } oss_mst_e;

  // Limits an analog value to the documented range.
  function automatic logic [7:0] ana_clamp(input logic [7:0] v);
    ana_clamp = (v > ANALOG_MAX) ? ANALOG_MAX : v;
  endfunction : ana_clamp

endpackage : oss_pkg

/* shared/oss_link_if.sv */
// Cyclic exchange and configuration link between master and device.
interface oss_link_if;
  logic cyc_stb; // One-cycle cyclic transfer.
  logic [3:0] cyc_digital; // Task digital requests.
  logic [31:0] cyc_analog; // Task analog requests, ch1 in bits 7:0.
  logic [7:0] cyc_valid; // Safe operation valid byte.
  logic cfg_wr; // One-cycle configuration write.
  logic [2:0] cfg_idx; // Configuration index.
  logic [7:0] cfg_data; // Configuration data.
  logic [7:0] output_status; // Device status byte.
  logic module_healthy; // High in normal operation.

  modport dev (
    input cyc_stb, cyc_digital, cyc_analog, cyc_valid, cfg_wr, cfg_idx, cfg_data,
    output output_status, module_healthy
  );

  modport mst (
    output cyc_stb, cyc_digital, cyc_analog, cyc_valid, cfg_wr, cfg_idx, cfg_data,
    input output_status, module_healthy
  );
endinterface : oss_link_if

/* rtl/oss_master.sv */
// Master end: software register port, cyclic exchange and configuration writes.
module oss_master #(
  parameter int CYCLE_CYC = oss_pkg::MIN_CYCLE_CYC, // Requested bus cycle in clocks.
  parameter int MIN_CYCLE_CYC = oss_pkg::MIN_CYCLE_CYC // Shortest allowed bus cycle in clocks.
) (
  input wire logic clk, // 100 MHz clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  oss_link_if.mst lnk, // Link to the device.
  input wire logic [5:0] addr, // Register byte address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [15:0] rdata, // Read data, valid the cycle after rd.
  input wire logic link_hold // High suppresses transfers, modelling a broken link.
);

  // Never faster than the shortest cycle, whatever is requested.
  localparam int PERIOD = (CYCLE_CYC < MIN_CYCLE_CYC) ? MIN_CYCLE_CYC : CYCLE_CYC;

  // The four analog request words sit on consecutive word addresses.
  function automatic logic is_ana_addr(input logic [5:0] a);
    is_ana_addr = a >= oss_pkg::A_ANALOG_CH1 && a <= oss_pkg::A_ANALOG_CH4 && a[1:0] == 2'b00;
  endfunction : is_ana_addr

  // Channel number of an analog request word address.
  function automatic logic [1:0] ana_sel(input logic [5:0] a);
    ana_sel = 2'(a[5:2] - oss_pkg::A_ANALOG_CH1[5:2]);
  endfunction : ana_sel

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic valid_r;
  logic run_r;
  logic [3:0] dig_r;
  logic [7:0] ana_r [oss_pkg::NCH];
  logic [7:0] status_r;
  logic healthy_r;

  // Reset reinitialises the valid copy; software must set it again.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_r <= 1'b0;
      run_r <= 1'b0;
      dig_r <= 4'h0;
      for (int i = 0; i < oss_pkg::NCH; i++) begin
        ana_r[i] <= 8'h00;
      end
    end else if (wr) begin
      if (addr == oss_pkg::A_CTRL) begin
        valid_r <= wdata[0];
        run_r <= wdata[1];
      end
      if (addr == oss_pkg::A_DIGITAL) begin
        dig_r <= wdata[3:0];
      end
      if (is_ana_addr(addr)) begin
        ana_r[ana_sel(addr)] <= wdata[7:0];
      end
    end
  end

  // Configuration writes pass straight to the link one cycle later.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk.cfg_wr <= 1'b0;
      lnk.cfg_idx <= 3'h0;
      lnk.cfg_data <= 8'h00;
    end else begin
      lnk.cfg_wr <= wr && addr == oss_pkg::A_CONFIG;
      if (wr && addr == oss_pkg::A_CONFIG) begin
        lnk.cfg_idx <= wdata[10:8];
        lnk.cfg_data <= wdata[7:0];
      end
    end
  end

  // Reads answer in the next cycle; unmapped addresses read zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0;
    end else if (rd) begin
      case (addr)
        oss_pkg::A_CTRL: rdata <= {14'h0, run_r, valid_r};
        oss_pkg::A_DIGITAL: rdata <= {12'h0, dig_r};
        oss_pkg::A_STATUS: rdata <= {8'h00, status_r};
        oss_pkg::A_HEALTH: rdata <= {15'h0, healthy_r};
        default: begin
          if (is_ana_addr(addr)) begin
            rdata <= {8'h00, ana_r[ana_sel(addr)]};
          end else begin
            rdata <= 16'h0;
          end
        end
      endcase
    end else begin
      rdata <= 16'h0;
    end
  end

  // ----------------------------------------------------------------
  // Cyclic exchange
  // ----------------------------------------------------------------
  oss_pkg::oss_mst_e state_r;
  logic [31:0] cnt_r;
  logic sent_r;

  // One transfer per period; a held link skips the slot but keeps the pace.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= oss_pkg::M_WAIT;
      cnt_r <= 32'h0;
      lnk.cyc_stb <= 1'b0;
      lnk.cyc_digital <= 4'h0;
      lnk.cyc_analog <= 32'h0;
      lnk.cyc_valid <= 8'h00;
    end else begin
      lnk.cyc_stb <= 1'b0;
      case (state_r)
        oss_pkg::M_WAIT: begin
          if (cnt_r >= 32'(PERIOD - 1)) begin
            cnt_r <= 32'h0;
            state_r <= oss_pkg::M_SEND;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
        oss_pkg::M_SEND: begin
          cnt_r <= 32'h1;
          state_r <= oss_pkg::M_WAIT;
          if (run_r && !link_hold) begin
            lnk.cyc_stb <= 1'b1;
            lnk.cyc_digital <= dig_r;
            lnk.cyc_valid <= {7'h00, valid_r};
            for (int i = 0; i < oss_pkg::NCH; i++) begin
              lnk.cyc_analog[8*i +: 8] <= ana_r[i];
            end
          end
        end
        default: state_r <= oss_pkg::M_WAIT;
      endcase
    end
  end

  // Device answers are captured two cycles after each transfer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sent_r <= 1'b0;
      status_r <= 8'h00;
      healthy_r <= 1'b0;
    end else begin
      sent_r <= lnk.cyc_stb;
      if (sent_r) begin
        status_r <= lnk.output_status;
        healthy_r <= lnk.module_healthy;
      end
    end
  end

endmodule : oss_master

/* tb/oss_link_assertions.sv */
// Checker for the cyclic link between the master and device ends.
module oss_link_assertions #(
  parameter int COMM_TIMEOUT_CYC = 50 // Idle clocks that mean link loss.
) (
  input wire logic clk, // Link clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic cyc_stb, // Cyclic transfer pulse.
  input wire logic [7:0] cyc_valid, // Valid byte.
  input wire logic [7:0] output_status, // Status byte.
  input wire logic module_healthy // Normal operation flag.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Idle clocks since the last transfer; saturates so a long outage never wraps.
  int idle_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      idle_r <= 0;
    else if (cyc_stb)
      idle_r <= 0;
    else if (idle_r < COMM_TIMEOUT_CYC + 8)
      idle_r <= idle_r + 1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_valid_reserved_zero: assert property (cyc_stb |-> cyc_valid[7:1] == 7'h00)
    else $error("reserved valid bits set");
  a_normal_on_valid: assert property (cyc_stb && cyc_valid[0] |=> module_healthy)
    else $error("valid transfer did not restore normal mode");
  a_safe_on_clear: assert property (cyc_stb && !cyc_valid[0] |=> !module_healthy)
    else $error("cleared valid bit left normal mode");
  a_safe_stays: assert property (!module_healthy && !cyc_stb |=> !module_healthy)
    else $error("safe state left without a transfer");
  a_rise_cause: assert property ($rose(module_healthy) |-> $past(cyc_stb) && $past(cyc_valid[0]))
    else $error("normal mode entered without valid transfer");
  a_comm_loss: assert property (idle_r >= COMM_TIMEOUT_CYC + 4 |-> !module_healthy)
    else $error("link loss did not enter safe state");
  a_health_holds: assert property (module_healthy && !cyc_stb && idle_r < COMM_TIMEOUT_CYC - 2
    |=> module_healthy)
    else $error("normal mode dropped while link alive");
  a_stb_spacing: assert property (cyc_stb |=> !cyc_stb [*8])
    else $error("transfers too close together");
  a_status_reserved: assert property (output_status[6:5] == 2'b00)
    else $error("reserved status bits set");

  c_valid: cover property (cyc_stb && cyc_valid[0]);
  c_clear: cover property (cyc_stb && !cyc_valid[0]);
  c_loss: cover property ($fell(module_healthy) && !$past(cyc_stb));
endmodule : oss_link_assertions

/* tb/tb_top.sv */
// Self-checking bench joining the master and device ends over the link.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COMM = 50;
  typedef struct packed {
    logic [7:0] typ;
    logic [3:0] dig;
    logic [7:0] ana;
    logic [3:0] e_dig;
    logic [31:0] e_ana;
  } oss_row_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic link_hold = 1'b0;
  logic zc_polarity = 1'b0;
  logic [3:0] fire_sense_stb = 4'h0;
  logic [3:0] neutral_ok = 4'hF;
  logic [15:0] rdata;
  logic [3:0] chan_is_analog;
  logic [3:0] chan_digital_cmd;
  logic [31:0] chan_analog_cmd;
  logic safe_state_active;
  logic [15:0] v;
  int err_count = 0;
  int checks_done = 0;
  oss_row_s rows [3] = '{'{8'h00, 4'hA, 8'h32, 4'hA, 32'h0}, '{8'h0F, 4'hA, 8'h96, 4'h0, 32'h64},
    '{8'h05, 4'hF, 8'h10, 4'hA, 32'h10}};

  oss_link_if lnk ();
  oss_master #(.CYCLE_CYC(20), .MIN_CYCLE_CYC(20)) oss_master_i (.clk(clk), .reset_n(reset_n), .lnk(lnk.mst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_hold(link_hold));
  oss_device #(.COMM_TIMEOUT_CYC(COMM), .ZC_TIMEOUT_CYC(100)) oss_device_i (.clk(clk), .reset_n(reset_n),
    .lnk(lnk.dev), .zc_polarity(zc_polarity), .fire_sense_stb(fire_sense_stb), .neutral_ok(neutral_ok),
    .chan_is_analog(chan_is_analog), .chan_digital_cmd(chan_digital_cmd), .chan_analog_cmd(chan_analog_cmd),
    .safe_state_active(safe_state_active));
  oss_link_assertions #(.COMM_TIMEOUT_CYC(COMM)) oss_link_assertions_i (.clk(clk), .reset_n(reset_n),
    .cyc_stb(lnk.cyc_stb), .cyc_valid(lnk.cyc_valid), .output_status(lnk.output_status),
    .module_healthy(lnk.module_healthy));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rreg(input logic [5:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rreg

  // Bounded wait for a transfer, returning once the device has reacted.
  task automatic wait_stb();
    int n = 0;
    @(negedge clk);
    while (lnk.cyc_stb !== 1'b1) begin
      if (n == 100) begin
        err_count++;
        close_out();
      end
      n++;
      @(negedge clk);
    end
    @(negedge clk);
  endtask : wait_stb

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("type", chan_is_analog, 4'hF);
    // Safe values armed but not yet usable: no valid transfer has happened.
    wreg(6'h20, 16'h0600);
    wreg(6'h20, 16'h010F);
    wreg(6'h04, 16'h000F);
    wreg(6'h00, 16'h0002);
    wait_stb();
    chk("init dig", chan_digital_cmd, 4'h0);
    chk("init health", lnk.module_healthy, 1'b0);
    foreach (rows[i]) begin
      wreg(6'h20, {8'h06, rows[i].typ});
      wreg(6'h04, {12'h000, rows[i].dig});
      wreg(6'h08, {8'h00, rows[i].ana});
      wreg(6'h00, 16'h0003);
      wait_stb();
      wait_stb();
      chk("row dig", chan_digital_cmd, rows[i].e_dig);
      chk("row ana", chan_analog_cmd, rows[i].e_ana);
    end
    // Static replacement on link loss, then automatic recovery.
    wreg(6'h20, 16'h0609);
    wreg(6'h20, 16'h0105);
    wreg(6'h20, 16'h0296);
    wreg(6'h20, 16'h0520);
    wreg(6'h04, 16'h000A);
    wait_stb();
    @(posedge clk);
    link_hold <= 1'b1;
    repeat (COMM + 30) @(posedge clk);
    @(negedge clk);
    chk("loss dig", chan_digital_cmd, 4'h4);
    chk("loss ana", chan_analog_cmd, 32'h20000064);
    chk("loss flag", safe_state_active, 1'b1);
    @(posedge clk);
    link_hold <= 1'b0;
    wait_stb();
    chk("back dig", chan_digital_cmd, 4'h2);
    chk("back ana", chan_analog_cmd, 32'h10);
    rreg(6'h1C, v);
    chk("health", v, 16'h0001);
    // Hold mode keeps the last valid request while later requests are not valid.
    wreg(6'h20, 16'h0600);
    wreg(6'h20, 16'h0001);
    wreg(6'h04, 16'h0003);
    wait_stb();
    wait_stb();
    wreg(6'h00, 16'h0002);
    wreg(6'h04, 16'h000C);
    wait_stb();
    wait_stb();
    chk("hold dig", chan_digital_cmd, 4'h3);
    chk("hold flag", safe_state_active, 1'b1);
    wreg(6'h00, 16'h0003);
    // A transfer launched at the write's own edge still carries the cleared bit.
    wait_stb();
    wait_stb();
    chk("resume dig", chan_digital_cmd, 4'hC);
    // Open load on channel 3 and a positive half-wave.
    @(posedge clk);
    fire_sense_stb <= 4'h4;
    neutral_ok <= 4'hB;
    zc_polarity <= 1'b1;
    @(posedge clk);
    fire_sense_stb <= 4'h0;
    wait_stb();
    wait_stb();
    rreg(6'h18, v);
    chk("status", v, 16'h0014);
    repeat (120) @(posedge clk);
    wait_stb();
    rreg(6'h18, v);
    chk("dropout", v, 16'h0094);
    @(posedge clk);
    zc_polarity <= 1'b0;
    wait_stb();
    wait_stb();
    rreg(6'h18, v);
    chk("negative", v, 16'h0004);
    rreg(6'h3C, v);
    chk("unmapped", v, 16'h0000);
    rreg(6'h08, v);
    chk("ana readback", v, 16'h0010);
    // Reset in mid-run drops every command.
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("reset dig", chan_digital_cmd, 4'h0);
    rreg(6'h00, v);
    chk("reset ctrl", v, 16'h0000);
    rreg(6'h1C, v);
    chk("reset health", v, 16'h0000);
    close_out();
  end
endmodule : tb_top
